/* design/rdi2c_target.v */
// I2C configuration target with register file for the redriver crosspoint switch
//
// Overview of operation
// - Any mode value may be written to the mode field at any time.
// - Address byte with write flag is acknowledged when it matches.
// - First byte after a write address is the register pointer, acknowledged.
// - Further write bytes are acknowledged and stored at mapped offsets; stop ends the transfer.
// - Reads start at zero after reset, else one past the last byte read or written, or at a pointer-only write.
// - Master ACK sends next byte; NACK releases data and waits for stop.
// - Repeated start after pointer write reads from that pointer.
// - Pointer-only write sets the read start without changing registers.
// - Pointer increments after every read byte, acknowledged or not.
// - General register decodes mode, flip and limited-redriver bit.
// - Adaptive control values select fast or full adaptation.
// - Threshold register holds the fast-adaptation eye-height limit.
// - Pre-shoot/de-emphasis register feeds its output only in limited-redriver mode; swing register feeds output_swing always.
// - Equalizer registers used only while override bit is set; else straps.
// - General bit 2 selects connector orientation.
`timescale 1ns/1ps
`include "rdi2c_defines.vh"
module rdi2c_target (
  input wire clk, // 100 MHz system clock
  input wire reset_n, // Synchronous reset, active low
  input wire scl_in, // I2C clock pin level
  input wire sda_in, // I2C data pin level
  output reg sda_out, // Data pin drive value, always low
  output reg sda_oe, // Data pin drive enable, high pulls low
  input wire [1:0] addr_strap_high, // Four-level address strap, 0/R/F/1
  input wire [1:0] addr_strap_low, // Four-level address strap, 0/R/F/1
  input wire [7:0] strap_dp_eq, // Pin-sampled DP equalizer setting
  input wire [7:0] strap_usb_eq, // Pin-sampled USB-C receiver equalizer
  input wire [7:0] strap_uprx_eq, // Pin-sampled upstream receive equalizer
  output reg [1:0] mux_mode_select, // Mode field, 0 disables switch
  output reg flip_orient, // 1 flipped orientation
  output reg limited_redriver, // Limited redriver on upstream transmitter
  output reg [7:0] dp01_eq_out, // Equalizer in use, DP lanes 0 and 1
  output reg [7:0] dp23_eq_out, // Equalizer in use, DP lanes 2 and 3
  output reg [7:0] short_eq_out, // Equalizer in use, short channel
  output reg [7:0] long_eq_out, // Equalizer in use, long channel
  output reg [7:0] uprx_eq_out, // Equalizer in use, upstream receive lane
  output reg aeq_fast_en, // Fast adaptation enabled
  output reg aeq_full_en, // Full adaptation enabled
  output reg [7:0] fast_adapt_threshold_field, // Eye-height threshold
  output reg [7:0] tx_preshoot_deemph, // Pre-shoot and de-emphasis setting
  output reg [7:0] output_swing // Output swing control
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_WRITE = 3'd2;
  localparam S_READ = 3'd3;
  localparam S_RACK = 3'd4;
  localparam S_WAIT = 3'd5;
  // Start seen; the SCL fall that closes the start is not a data bit
  localparam S_START = 3'd6;

  // Register index 0..9, 4'hf for unmapped offsets
  function [3:0] reg_index;
    input [7:0] ofs;
    begin
      case (ofs)
        `RDI2C_OFS_GENERAL: reg_index = 4'h0;
        `RDI2C_OFS_TXEQ: reg_index = 4'h1;
        `RDI2C_OFS_DP01EQ: reg_index = 4'h2;
        `RDI2C_OFS_DP23EQ: reg_index = 4'h3;
        `RDI2C_OFS_AEQ_CTRL: reg_index = 4'h4;
        `RDI2C_OFS_AEQ_THR: reg_index = 4'h5;
        `RDI2C_OFS_LONG_EQ: reg_index = 4'h6;
        `RDI2C_OFS_SHORT_EQ: reg_index = 4'h7;
        `RDI2C_OFS_UPRX_EQ: reg_index = 4'h8;
        `RDI2C_OFS_SWING: reg_index = 4'h9;
        default: reg_index = 4'hf;
      endcase
    end
  endfunction

  // Upper five address bits for one level of the high address strap
  function [4:0] strap_hi_bits;
    input [1:0] lvl;
    begin
      case (lvl)
        `RDI2C_STRAP_0: strap_hi_bits = 5'b10001;
        `RDI2C_STRAP_R: strap_hi_bits = 5'b01000;
        `RDI2C_STRAP_F: strap_hi_bits = 5'b00100;
        default: strap_hi_bits = 5'b00011;
      endcase
    end
  endfunction

  reg [7:0] regs_q [0:9];
  reg [1:0] scl_s_q, sda_s_q;
  reg scl_q, sda_q;
  reg [2:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] ptr_q;
  reg ptr_loaded_q;
  reg ack_phase_q;
  reg [6:0] my_addr_q;
  reg [7:0] rd_byte;
  reg [4:0] hi5;
  reg [3:0] ridx;
  // Strap pins: high strap, low strap, DP, USB-C and upstream equalizer levels
  reg [27:0] strap_s1_q;
  reg [27:0] strap_s2_q;
  integer i;

  wire [1:0] strap_hi_sync = strap_s2_q[27:26];
  wire [1:0] strap_lo_sync = strap_s2_q[25:24];
  wire [7:0] strap_dp_sync = strap_s2_q[23:16];
  wire [7:0] strap_usb_sync = strap_s2_q[15:8];
  wire [7:0] strap_uprx_sync = strap_s2_q[7:0];

  wire scl_rise = ~scl_q & scl_s_q[1];
  wire scl_fall = scl_q & ~scl_s_q[1];
  wire start_cond = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  wire stop_cond = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
  wire [7:0] shift_in = {shift_q[6:0], sda_s_q[1]};
  wire eq_sel = regs_q[0][`RDI2C_GEN_EQSEL_BIT];

  always @* begin
    ridx = reg_index(ptr_q);
    rd_byte = (ridx == 4'hf) ? 8'h00 : regs_q[ridx];
    hi5 = strap_hi_bits(strap_hi_sync);
  end

  // Straps are pins too; they pass two flip-flops like SCL and SDA
  always @(posedge clk) begin
    if (!reset_n) begin
      strap_s1_q <= 28'h0000000;
      strap_s2_q <= 28'h0000000;
    end else begin
      strap_s1_q <= {addr_strap_high, addr_strap_low, strap_dp_eq, strap_usb_eq, strap_uprx_eq};
      strap_s2_q <= strap_s1_q;
    end
  end

  // Pins pass two flip-flops before use
  always @(posedge clk) begin
    if (!reset_n) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
    end
  end

  // Straps are re-read each clock; the address only matters at an address byte
  always @(posedge clk) begin
    if (!reset_n)
      my_addr_q <= 7'h00;
    else
      my_addr_q <= {hi5, strap_lo_sync};
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      bit_q <= 3'd0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      ptr_loaded_q <= 1'b0;
      ack_phase_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      regs_q[0] <= `RDI2C_RST_GENERAL;
      for (i = 1; i < 10; i = i + 1)
        regs_q[i] <= `RDI2C_RST_OTHER;
    end else if (start_cond) begin
      // Repeated start keeps the pointer for the read that follows
      state_q <= S_START;
      bit_q <= 3'd0;
      ack_phase_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state_q <= S_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise && !ack_phase_q) begin
      if (state_q == S_ADDR || state_q == S_WRITE)
        shift_q <= shift_in;
      if (state_q == S_RACK) begin
        if (sda_s_q[1]) begin
          state_q <= S_WAIT;
        end else begin
          // Master acknowledged; the next byte starts at the coming SCL fall
          ack_phase_q <= 1'b1;
        end
      end
    end else if (scl_fall) begin
      case (state_q)
        S_START: begin
          state_q <= S_ADDR;
          bit_q <= 3'd0;
        end
        S_ADDR: begin
          if (ack_phase_q) begin
            ack_phase_q <= 1'b0;
            sda_oe <= 1'b0;
            bit_q <= 3'd0;
            if (shift_q[0]) begin
              state_q <= S_READ;
              sda_oe <= ~rd_byte[7];
              shift_q <= {rd_byte[6:0], 1'b1};
            end else begin
              state_q <= S_WRITE;
              ptr_loaded_q <= 1'b0;
            end
          end else if (bit_q == 3'd7) begin
            if (shift_q[7:1] == my_addr_q) begin
              ack_phase_q <= 1'b1;
              sda_oe <= 1'b1;
            end else begin
              state_q <= S_WAIT;
            end
          end else begin
            bit_q <= bit_q + 3'd1;
          end
        end
        S_WRITE: begin
          if (ack_phase_q) begin
            ack_phase_q <= 1'b0;
            sda_oe <= 1'b0;
            bit_q <= 3'd0;
          end else if (bit_q == 3'd7) begin
            ack_phase_q <= 1'b1;
            sda_oe <= 1'b1;
            if (!ptr_loaded_q) begin
              ptr_q <= shift_q;
              ptr_loaded_q <= 1'b1;
            end else begin
              if (ridx != 4'hf)
                regs_q[ridx] <= shift_q;
              ptr_q <= ptr_q + 8'h01;
            end
          end else begin
            bit_q <= bit_q + 3'd1;
          end
        end
        S_READ: begin
          if (bit_q == 3'd7) begin
            // Release for the master's acknowledge bit
            sda_oe <= 1'b0;
            state_q <= S_RACK;
            ptr_q <= ptr_q + 8'h01;
            bit_q <= 3'd0;
          end else begin
            sda_oe <= ~shift_q[7];
            shift_q <= {shift_q[6:0], 1'b1};
            bit_q <= bit_q + 3'd1;
          end
        end
        S_RACK: begin
          // Pointer already advanced at the end of the previous byte
          if (ack_phase_q) begin
            ack_phase_q <= 1'b0;
            state_q <= S_READ;
            bit_q <= 3'd0;
            sda_oe <= ~rd_byte[7];
            shift_q <= {rd_byte[6:0], 1'b1};
          end else begin
            sda_oe <= 1'b0;
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Register fields drive the switch; straps steer equalizers unless overridden
  always @(posedge clk) begin
    if (!reset_n) begin
      mux_mode_select <= 2'b01;
      flip_orient <= 1'b0;
      limited_redriver <= 1'b0;
      dp01_eq_out <= 8'h00;
      dp23_eq_out <= 8'h00;
      short_eq_out <= 8'h00;
      long_eq_out <= 8'h00;
      uprx_eq_out <= 8'h00;
      aeq_fast_en <= 1'b0;
      aeq_full_en <= 1'b0;
      fast_adapt_threshold_field <= 8'h00;
      tx_preshoot_deemph <= 8'h00;
      output_swing <= 8'h00;
    end else begin
      mux_mode_select <= regs_q[0][1:0];
      flip_orient <= regs_q[0][`RDI2C_GEN_FLIP_BIT];
      limited_redriver <= regs_q[0][`RDI2C_GEN_LIMIT_BIT];
      dp01_eq_out <= eq_sel ? regs_q[2] : strap_dp_sync;
      dp23_eq_out <= eq_sel ? regs_q[3] : strap_dp_sync;
      long_eq_out <= eq_sel ? regs_q[6] : strap_usb_sync;
      short_eq_out <= eq_sel ? regs_q[7] : strap_usb_sync;
      uprx_eq_out <= eq_sel ? regs_q[8] : strap_uprx_sync;
      aeq_fast_en <= (regs_q[4] == `RDI2C_AEQ_FAST);
      aeq_full_en <= (regs_q[4] == `RDI2C_AEQ_FULL);
      fast_adapt_threshold_field <= regs_q[5];
      tx_preshoot_deemph <= regs_q[0][`RDI2C_GEN_LIMIT_BIT] ? regs_q[1] : 8'h00;
      output_swing <= regs_q[9];
    end
  end
endmodule // rdi2c_target

/* design/rdi2c_defines.vh */
// Constants for the redriver I2C configuration target
`ifndef RDI2C_DEFINES_VH
`define RDI2C_DEFINES_VH
`define RDI2C_OFS_GENERAL 8'h0a
`define RDI2C_OFS_TXEQ 8'h0b
`define RDI2C_OFS_DP01EQ 8'h10
`define RDI2C_OFS_DP23EQ 8'h11
`define RDI2C_OFS_AEQ_CTRL 8'h1c
`define RDI2C_OFS_AEQ_THR 8'h1d
`define RDI2C_OFS_LONG_EQ 8'h1e
`define RDI2C_OFS_SHORT_EQ 8'h20
`define RDI2C_OFS_UPRX_EQ 8'h21
`define RDI2C_OFS_SWING 8'h32
`define RDI2C_RST_GENERAL 8'h01
`define RDI2C_RST_OTHER 8'h00
`define RDI2C_GEN_LIMIT_BIT 7
`define RDI2C_GEN_EQSEL_BIT 4
`define RDI2C_GEN_FLIP_BIT 2
`define RDI2C_AEQ_FAST 8'h81
`define RDI2C_AEQ_FULL 8'h83
`define RDI2C_STRAP_0 2'h0
`define RDI2C_STRAP_R 2'h1
`define RDI2C_STRAP_F 2'h2
`define RDI2C_STRAP_1 2'h3
`endif

/* bench/rdi2c_master.sv */
// I2C bus master model for the redriver configuration target
`timescale 1ns/1ps
module rdi2c_master (
  input wire clk, // Bench clock
  input wire sda_line, // Resolved SDA level, pulled up
  output logic scl, // SCL, idle high, still outside frames
  output logic sda_drv // 0 pulls SDA low, 1 releases it
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task hp;
    repeat (16) @(posedge clk);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task st;
    sda_drv <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda_drv <= 1'b0;
    hp;
    scl <= 1'b0;
    hp;
  endtask
  // SDA moves 16 clocks after SCL falls, never near an SCL edge
  task bt(input logic b, output logic s);
    sda_drv <= b;
    hp;
    scl <= 1'b1;
    hp;
    s = sda_line;
    scl <= 1'b0;
    hp;
  endtask
  task wb(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bt(b[i], s);
    bt(1'b1, ack_n);
  endtask
  task rb(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bt(1'b1, s);
      d = {d[6:0], s};
    end
    bt(nack, s);
  endtask
  task sp;
    sda_drv <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_drv <= 1'b1;
    hp;
  endtask
endmodule // rdi2c_master

/* bench/rdi2c_assertions.sv */
// Concurrent checks on the redriver I2C target ports
`timescale 1ns/1ps
module rdi2c_checker (
  input wire clk, // Clock
  input wire reset_n, // Reset, active low
  input wire scl_in, // SCL level
  input wire sda_out, // SDA drive value
  input wire sda_oe, // SDA drive enable
  input wire [1:0] mux_mode_select, // Mode field
  input wire limited_redriver, // Limited redriver
  input wire aeq_fast_en, // Fast adaptation
  input wire aeq_full_en, // Full adaptation
  input wire [7:0] tx_preshoot_deemph // Pre-shoot setting
);
  logic [7:0] hi_cnt_q;
  // Counts how long SCL has been high; saturates so idle time cannot wrap
  always @(posedge clk) begin
    hi_cnt_q <= (!reset_n || !scl_in) ? 8'h00 : hi_cnt_q + {7'h0, hi_cnt_q != 8'hff};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  reset_vals_a: assert property (disable iff (1'b0) !reset_n ##1 !reset_n |->
    mux_mode_select == 2'b01 && !limited_redriver && !aeq_fast_en && !aeq_full_en)
    else $error("outputs not at reset values");
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda drive began with scl high");
  oe_hold_high_a: assert property (scl_in && $past(scl_in, 4) |-> $stable(sda_oe))
    else $error("sda drive changed while scl high");
  oe_release_a: assert property ($rose(sda_oe) |-> ##[1:600] !sda_oe)
    else $error("sda drive never released");
  idle_quiet_a: assert property (hi_cnt_q > 8'd40 |-> !sda_oe)
    else $error("sda driven while bus idle");
  aeq_excl_a: assert property (!(aeq_fast_en && aeq_full_en))
    else $error("both adaptation modes on");
  tx_limit_a: assert property (tx_preshoot_deemph != 8'h00 |-> limited_redriver)
    else $error("pre-shoot set in linear mode");
endmodule // rdi2c_checker
bind rdi2c_target rdi2c_checker i_rdi2c_checker (.clk(clk), .reset_n(reset_n),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .mux_mode_select(mux_mode_select),
  .limited_redriver(limited_redriver), .aeq_fast_en(aeq_fast_en),
  .aeq_full_en(aeq_full_en), .tx_preshoot_deemph(tx_preshoot_deemph));

/* bench/tb.sv */
// Self-checking bench for the redriver I2C configuration target
`timescale 1ns/1ps
`include "rdi2c_defines.vh"
module tb;
  localparam logic [7:0] AW = 8'h44; // Address byte for straps R and F, write
  logic clk, reset_n, sda_oe, sda_out, scl, sda_drv, flip_orient, limited_redriver;
  logic aeq_fast_en, aeq_full_en;
  logic [1:0] mux_mode_select;
  logic [7:0] dp01, uprx, thr, tx, swing, rd, v;
  logic [7:0] dp23, lng, sht;
  wire sda_line = sda_drv & ~(sda_oe & ~sda_out);
  int n_errors = 0;
  int tests_run = 0;
  rdi2c_target i_rdi2c_target (.clk(clk), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_high(`RDI2C_STRAP_R), .addr_strap_low(`RDI2C_STRAP_F),
    .strap_dp_eq(8'h3c), .strap_usb_eq(8'h5a), .strap_uprx_eq(8'h0f),
    .mux_mode_select(mux_mode_select), .flip_orient(flip_orient),
    .limited_redriver(limited_redriver), .dp01_eq_out(dp01), .dp23_eq_out(dp23),
    .short_eq_out(sht), .long_eq_out(lng), .uprx_eq_out(uprx), .aeq_fast_en(aeq_fast_en),
    .aeq_full_en(aeq_full_en), .fast_adapt_threshold_field(thr),
    .tx_preshoot_deemph(tx), .output_swing(swing));
  rdi2c_master i_rdi2c_master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task ack(input logic [7:0] b, input logic e);
    logic s;
    i_rdi2c_master.wb(b, s);
    chk("ack", {7'h0, e}, {7'h0, s});
  endtask
  task reg_wr(input logic [7:0] o, input logic [7:0] d);
    i_rdi2c_master.st;
    ack(AW, 1'b0);
    ack(o, 1'b0);
    ack(d, 1'b0);
    i_rdi2c_master.sp;
  endtask
  // Offset given: write phase, repeated start; otherwise plain read
  task reg_rd(input logic with_ofs, input logic [7:0] o, output logic [7:0] d);
    i_rdi2c_master.st;
    if (with_ofs) begin
      ack(AW, 1'b0);
      ack(o, 1'b0);
      i_rdi2c_master.st;
    end
    ack(AW | 8'h01, 1'b0);
    i_rdi2c_master.rb(1'b1, d);
    i_rdi2c_master.sp;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  initial begin
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("mode", 8'h01, {6'h0, mux_mode_select});
    chk("dp01", 8'h3c, dp01);
    chk("dp23", 8'h3c, dp23);
    chk("long", 8'h5a, lng);
    chk("short", 8'h5a, sht);
    i_rdi2c_master.st;
    ack(AW, 1'b0);
    ack(8'h0a, 1'b0);
    i_rdi2c_master.sp;
    reg_rd(1'b0, 8'h00, rd);
    chk("rd0a", 8'h01, rd);
    reg_rd(1'b0, 8'h00, rd);
    chk("rd0b", 8'h00, rd);
    i_rdi2c_master.st;
    ack(AW, 1'b0);
    ack(8'h0a, 1'b0);
    ack(8'h91, 1'b0);
    ack(8'h24, 1'b0);
    i_rdi2c_master.sp;
    chk("tx", 8'h24, tx);
    chk("dp01", 8'h00, dp01);
    reg_rd(1'b1, 8'h0b, rd);
    chk("rd0b", 8'h24, rd);
    reg_rd(1'b0, 8'h00, rd);
    chk("rd0c", 8'h00, rd);
    reg_wr(8'h10, 8'h55);
    chk("dp01", 8'h55, dp01);
    for (int i = 0; i < 16; i++) begin
      v = {i[3], 3'b001, 1'b0, i[2:0]};
      if (i[1]) reg_wr(8'h0a, v & 8'hfc);
      reg_wr(8'h0a, v);
      chk("mode", {6'h0, v[1:0]}, {6'h0, mux_mode_select});
      chk("flip", {7'h0, v[2]}, {7'h0, flip_orient});
      chk("limit", {7'h0, v[7]}, {7'h0, limited_redriver});
      chk("tx", v[7] ? 8'h24 : 8'h00, tx);
    end
    reg_wr(8'h1c, `RDI2C_AEQ_FAST);
    chk("aeq", 8'h01, {6'h0, aeq_full_en, aeq_fast_en});
    reg_wr(8'h1c, `RDI2C_AEQ_FULL);
    chk("aeq", 8'h02, {6'h0, aeq_full_en, aeq_fast_en});
    reg_wr(8'h1d, 8'h10);
    chk("thr", 8'h10, thr);
    i_rdi2c_master.st;
    ack(AW, 1'b0);
    ack(8'h1c, 1'b0);
    i_rdi2c_master.st;
    ack(AW | 8'h01, 1'b0);
    i_rdi2c_master.rb(1'b0, rd);
    chk("rd1c", `RDI2C_AEQ_FULL, rd);
    i_rdi2c_master.rb(1'b1, rd);
    chk("rd1d", 8'h10, rd);
    i_rdi2c_master.sp;
    reg_wr(8'h32, 8'h40);
    chk("swing", 8'h40, swing);
    reg_wr(8'h0a, 8'h01);
    chk("dp01", 8'h3c, dp01);
    chk("uprx", 8'h0f, uprx);
    i_rdi2c_master.st;
    ack(AW ^ 8'h02, 1'b1);
    ack(8'h1d, 1'b1);
    ack(8'h00, 1'b1);
    i_rdi2c_master.sp;
    chk("thr", 8'h10, thr);
    print_verdict;
  end
endmodule // tb
